// File: dv/host_model.sv
// Host-side model issuing register command words
module host_model
  import kpc_pkg::*;
(
  input  wire logic   i_clk,
  output logic        o_cmd_valid,
  output logic [15:0] o_cmd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd       = 16'h0000;
    o_wdata     = 16'h0000;
  end

  // One word per strobe, held across the taking edge
  task automatic xfer(input logic rd, input logic [14:0] code,
                      input logic [15:0] d);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd       = {rd, code};
    o_wdata     = d;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    // Idle lines flip so stale values never pass for live ones
    o_cmd       = ~o_cmd;
    o_wdata     = ~o_wdata;
  endtask

  task automatic wr(input logic [14:0] code, input logic [15:0] d);
    xfer(1'b0, code, d);
  endtask

  task automatic rd(input logic [14:0] code);
    xfer(1'b1, code, ~o_wdata);
  endtask
endmodule // host_model

// File: dv/tb_top.sv
// Self-checking bench for the control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import kpc_pkg::*;

  localparam int US_C = 2;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        cmd_valid;
  logic [15:0] cmd;
  logic [15:0] wdata;
  logic        rd_valid;
  logic [15:0] rdata;
  logic        pen = 1'b0;
  logic        conv_start;
  logic [1:0]  avg;
  logic [1:0]  res;
  logic        ref_voltage_select;
  ref_mode_e   ref_mode;
  logic        dac_pd;
  logic [15:0] key_raw = 16'h0000;
  logic        det_on;
  logic        key_irq;
  logic [15:0] key_data;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] d;
  logic [15:0] base;
  logic [1:0]  rm;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_irq = 0;
  int          n;
  int          b;
  integer      seed = 32'h0C384A81;
  // Touch, touch zero settle, battery, temperature
  logic [15:0] st_w [4] = '{16'h0C02, 16'h0800, 16'h1806, 16'h2802};
  int          st_lo [4] = '{100 * US_C, 2, 1, 1};
  int          st_hi [4] = '{101 * US_C + 4, 5, 1, 1};

  always #2.5 i_clk = ~i_clk;

  host_model i_host_model (
    .i_clk       (i_clk),
    .o_cmd_valid (cmd_valid),
    .o_cmd       (cmd),
    .o_wdata     (wdata)
  );

  kpc_ctrl_regs #(.US_CYC(US_C)) i_kpc_ctrl_regs (
    .i_clk                (i_clk),
    .i_rst_n              (i_rst_n),
    .i_cmd_valid          (cmd_valid),
    .i_cmd                (cmd),
    .i_wdata              (wdata),
    .o_rd_valid           (rd_valid),
    .o_rdata              (rdata),
    .i_pen_detect         (pen),
    .o_conv_start         (conv_start),
    .o_average_select     (avg),
    .o_resolution_select  (res),
    .o_ref_voltage_select (ref_voltage_select),
    .o_ref_mode           (ref_mode),
    .o_dac_power_down     (dac_pd),
    .i_key_raw            (key_raw),
    .o_key_detect_on      (det_on),
    .o_key_irq            (key_irq),
    .o_key_data           (key_data)
  );

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_cmp(input logic [15:0] got, input logic [15:0] exp,
                        input logic [15:0] msk);
    chk(got & msk, exp & msk);
  endtask

  task automatic tmo();
    n_mismatch++;
    $display("wait limit reached at %0t", $time);
    conclude();
  endtask

  task automatic rd_exp(input logic [14:0] c, input logic [15:0] e,
                        input logic [15:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    i_host_model.rd(c);
  endtask

  task automatic wait_irq(input int lim);
    int k;
    k = n_irq;
    n = 0;
    while (n_irq == k && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    if (n_irq == k) tmo();
  endtask

  task automatic no_irq();
    int k;
    k = n_irq;
    repeat (30) @(negedge i_clk);
    chk(16'(n_irq), 16'(k));
  endtask

  // Read answers stand one cycle; the falling edge sees them settled
  always @(negedge i_clk) begin
    if (key_irq === 1'b1) n_irq++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) tmo();
      else rd_cmp(rdata, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd_exp(CMD_ADC_CTRL, 16'h0000, 16'hFFFF);
    rd_exp(CMD_DAC_CTRL, 16'h0000, 16'hFFFF);
    rd_exp(CMD_KEY_MASK, 16'h0000, 16'hFFFF);
    rd_exp(15'h0055, 16'h0000, 16'hFFFF);
    chk({15'h0, det_on}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      d = (16'($random(seed)) & 16'hC0FF) | 16'(i << 8);
      i_host_model.wr(CMD_ADC_CTRL, d);
      @(negedge i_clk);
      rm = d[9] ? REF_EXT : (d[8] ? REF_ON : REF_AUTO);
      chk({14'h0, avg}, {14'h0, d[7:6]});
      chk({15'h0, ref_voltage_select}, {15'h0, d[0]});
      chk({14'h0, res}, {14'h0, d[9:8]});
      chk({14'h0, ref_mode}, {14'h0, rm});
      rd_exp(CMD_ADC_CTRL, d & 16'h3FFF, 16'hFFFF);
    end
    for (int i = 0; i < 2; i++) begin
      d = 16'($random(seed));
      d[15] = i[0];
      i_host_model.wr(CMD_DAC_CTRL, d);
      @(negedge i_clk);
      chk({15'h0, dac_pd}, {15'h0, d[15]});
      rd_exp(CMD_DAC_CTRL, {d[15], 15'h0}, 16'hFFFF);
    end
    d = 16'($random(seed));
    i_host_model.wr(CMD_KEY_MASK, d);
    rd_exp(CMD_KEY_MASK, d, 16'hFFFF);
    // Settle delay per scan function, measured from the sampling edge
    for (int i = 0; i < 4; i++) begin
      i_host_model.wr(CMD_ADC_CTRL, st_w[i]);
      @(negedge i_clk);
      pen = 1'b1;
      // One-cycle pen pulse; n counts edges from the one that takes it
      @(negedge i_clk);
      pen = 1'b0;
      n = 1;
      while (conv_start !== 1'b1 && n < 5000) begin
        @(negedge i_clk);
        n++;
      end
      if (n >= 5000) tmo();
      chk(16'(n >= st_lo[i] && n <= st_hi[i]), 16'h0001);
    end
    // Keypad: one scan, then manual, auto and off
    i_host_model.wr(CMD_KEY_MASK, 16'h0001);
    i_host_model.wr(CMD_KEY_CTRL, 16'h0000);
    repeat (2000 * US_C + 100) @(negedge i_clk);
    rd_exp(CMD_KEY_CTRL, 16'h4000, 16'hFFFF);
    i_host_model.wr(CMD_KEY_CTRL, 16'h4000);
    key_raw = 16'h0001;
    no_irq();
    key_raw = 16'h0021;
    wait_irq(10);
    rd_exp(CMD_KEY_CTRL, 16'h8000, 16'hBFFF);
    key_raw = 16'h0000;
    i_host_model.wr(CMD_KEY_CTRL, 16'h87A5);
    rd_exp(CMD_KEY_CTRL, 16'h0700, 16'hBFFF);
    base = key_data;
    key_raw = 16'h0023;
    wait_irq(10);
    n = 0;
    while (key_data === base && n < 3000 * US_C) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 3000 * US_C) tmo();
    chk(16'(n >= 2000 * US_C - 2 && n <= 2000 * US_C + US_C + 10),
        16'h0001);
    chk(key_data, 16'h0022);
    rd_exp(CMD_KEY_CTRL, 16'hC700, 16'hFFFF);
    i_host_model.wr(CMD_KEY_CTRL, 16'hC000);
    @(negedge i_clk);
    chk({15'h0, det_on}, 16'h0000);
    key_raw = 16'h0100;
    no_irq();
    repeat (5) @(negedge i_clk);
    chk(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule // tb_top

// File: rtl/kpc_ctrl_regs.sv
// Control registers for ADC, DAC and keypad scanner
// Overview of operation
// (RULE1) Averaging field picks none, 4, 8 or 16 results.
// (RULE2) Settle field picks 0us to 100ms pen-to-conversion delay.
// (RULE3) Settle delay applies to X, Y and pressure measurements only.
// (RULE4) Settle field reads back exactly as written.
// (RULE5) Reference bit picks 1.0V or 2.5V and reads back as written.
// (RULE6) With scan function zero, resolution field sets reference power.
// (RULE7) Host writes zero scan function to change reference power.
// (RULE8) DAC bit 15 high powers DAC down, low powers it up.
// (RULE9) Keypad register: commands 15:14, debounce 13:11, hold 10:8.
// (RULE10) Keypad read shows press detected and data available.
// (RULE11) Command 00 scans once, then waits press, irq, waits host.
// (RULE12) Command 10 stops scan, waits press, irq, scans itself.
// (RULE13) Command 01 stops scan, waits press, irq, waits host.
// (RULE14) Command 11 stops scan and powers down press detection.
// (RULE15) Debounce field picks 2 to 120 milliseconds.
// (RULE16) Held key waits 100us or one to seven debounce times.
// (RULE17) Key mask holds one bit per key, bits 15 to 0.
// (RULE18) Write code has bit 15 clear, read code bit 15 set.
// (RULE19) Masked key never updates key data; bit is 4*(col-1)+(row-1).
// (RULE20) Reserved bits read zero and ignore writes.
module kpc_ctrl_regs #(
  parameter int US_CYC = kpc_pkg::US_CYCLES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_cmd_valid,
  input  wire logic [15:0]       i_cmd,
  input  wire logic [15:0]       i_wdata,
  output logic                   o_rd_valid,
  output logic [15:0]            o_rdata,
  input  wire logic              i_pen_detect,
  output logic                   o_conv_start,
  output logic [1:0]             o_average_select,
  output logic [1:0]             o_resolution_select,
  output logic                   o_ref_voltage_select,
  output kpc_pkg::ref_mode_e     o_ref_mode,
  output logic                   o_dac_power_down,
  input  wire logic [15:0]       i_key_raw,
  output logic                   o_key_detect_on,
  output logic                   o_key_irq,
  output logic [15:0]            o_key_data
);
  import kpc_pkg::*;

  logic        tick;
  logic        wr_en;
  logic        rd_en;
  logic [13:0] adc_ctrl_q;
  logic [15:0] key_mask_q;
  logic [2:0]  dbn_q;
  logic [2:0]  hld_q;
  logic        auto_q;
  logic        press_q;
  logic        avail_q;
  logic [15:0] key_meta_q;
  logic [15:0] key_sync_q;
  logic        any_key;
  logic        key_wr;
  logic        pen_touch;
  logic        settle_done;
  logic        direct_q;
  logic        key_load;
  logic        key_done;
  us_count_t   key_count;
  key_state_e  state_q;
  key_state_e  state_d;

  assign wr_en  = i_cmd_valid && !i_cmd[CMD_READ_BIT];          // see RULE18
  assign rd_en  = i_cmd_valid && i_cmd[CMD_READ_BIT];           // see RULE18
  assign key_wr = wr_en && i_cmd[14:0] == CMD_KEY_CTRL;

  us_tick_gen #(.DIV(US_CYC)) u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  // ADC control: all fields except the status bits are kept
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      adc_ctrl_q <= ADC_CTRL_RST;
    end else if (wr_en && i_cmd[14:0] == CMD_ADC_CTRL) begin
      adc_ctrl_q <= i_wdata[13:0];                             // see RULE4
    end
  end

  assign o_average_select     = adc_ctrl_q[ADC_AVG_LSB +: 2]; // see RULE1
  assign o_resolution_select  = adc_ctrl_q[ADC_RES_LSB +: 2];
  assign o_ref_voltage_select = adc_ctrl_q[ADC_RFV_BIT];       // see RULE5

  // Reference power only moves on a zero scan function write
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ref_mode <= REF_AUTO;
    end else if (wr_en && i_cmd[14:0] == CMD_ADC_CTRL &&
                 i_wdata[ADC_SCAN_LSB +: 4] == SCAN_REF_ONLY) begin // see RULE7
      case (i_wdata[ADC_RES_LSB +: 2])                        // see RULE6
        2'h0:    o_ref_mode <= REF_AUTO;
        2'h1:    o_ref_mode <= REF_ON;
        default: o_ref_mode <= REF_EXT;
      endcase
    end
  end

  // Touch measurements wait the settle time, others start at once
  assign pen_touch = adc_ctrl_q[ADC_SCAN_LSB +: 4] != SCAN_REF_ONLY &&
                     adc_ctrl_q[ADC_SCAN_LSB +: 4] <= SCAN_TOUCH_LAST;

  us_countdown u_settle (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (tick),
    .i_load  (i_pen_detect && pen_touch),                     // see RULE3
    .i_abort (1'b0),
    .i_count (SETTLE_US[adc_ctrl_q[ADC_SETTLE_LSB +: 3]]),    // see RULE2
    .o_done  (settle_done)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      direct_q <= 1'b0;
    end else begin
      direct_q <= i_pen_detect && !pen_touch;                 // see RULE3
    end
  end
  assign o_conv_start = settle_done || direct_q;

  // DAC power-down; lower bits are not stored
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_dac_power_down <= DAC_PD_RST;
    end else if (wr_en && i_cmd[14:0] == CMD_DAC_CTRL) begin
      o_dac_power_down <= i_wdata[DAC_PD_BIT];                 // see RULE8
    end
  end

  // Key mask and keypad timing fields
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      key_mask_q <= KEY_MASK_RST;
      dbn_q      <= KEY_DBN_RST;
      hld_q      <= KEY_HLD_RST;
    end else begin
      if (wr_en && i_cmd[14:0] == CMD_KEY_MASK) begin
        key_mask_q <= i_wdata;                                 // see RULE17
      end
      if (key_wr) begin
        dbn_q <= i_wdata[KEY_DBN_LSB +: 3];                    // see RULE9
        hld_q <= i_wdata[KEY_HLD_LSB +: 3];                    // see RULE9
      end
    end
  end

  // Key pins come from outside, so two stages before use
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      key_meta_q <= 16'h0000;
      key_sync_q <= 16'h0000;
    end else begin
      key_meta_q <= i_key_raw;
      key_sync_q <= key_meta_q;
    end
  end

  assign any_key = |(key_sync_q & ~key_mask_q);

  // Scan timer loads debounce, or hold after a held key
  always_comb begin
    key_count = DEBOUNCE_US[dbn_q];                            // see RULE15
    if (state_d == KS_HOLD) begin
      key_count = (hld_q == 3'h0) ? HOLD_SHORT_US               // see RULE16
                : 20'(DEBOUNCE_US[dbn_q] * hld_q);
    end
  end

  assign key_load = state_d != state_q &&
                    (state_d == KS_SCAN || state_d == KS_HOLD);

  us_countdown u_key_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (tick),
    .i_load  (key_load || (key_wr && state_d == KS_SCAN)),
    .i_abort (key_wr && state_d != KS_SCAN),
    .i_count (key_count),
    .o_done  (key_done)
  );

  always_comb begin
    state_d = state_q;
    if (key_wr) begin
      case (i_wdata[15:14])
        2'b00:   state_d = KS_SCAN;                            // see RULE11
        2'b11:   state_d = KS_OFF;                             // see RULE14
        default: state_d = KS_WAIT;                 // see RULE12 see RULE13
      endcase
    end else begin
      case (state_q)
        KS_WAIT: if (any_key) begin
          state_d = auto_q ? KS_SCAN : KS_HOST;     // see RULE11 see RULE12
        end
        KS_SCAN: if (key_done) begin
          state_d = (auto_q && any_key) ? KS_HOLD : KS_WAIT;
        end
        KS_HOLD: if (key_done) begin
          state_d = KS_SCAN;                                   // see RULE16
        end
        KS_OFF:  state_d = KS_OFF;
        KS_HOST: state_d = KS_HOST;
        default: state_d = KS_WAIT;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= KS_WAIT;
      auto_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (key_wr) begin
        auto_q <= i_wdata[15:14] == 2'b10;                     // see RULE12
      end
    end
  end

  assign o_key_detect_on = state_q != KS_OFF;                  // see RULE14

  // Press flag: a clearing write wins over detection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      press_q   <= 1'b0;
      o_key_irq <= 1'b0;
    end else begin
      o_key_irq <= state_q == KS_WAIT && any_key && !key_wr;
      if (state_q == KS_WAIT && any_key && !key_wr) begin
        press_q <= 1'b1;                                       // see RULE10
      end else if (key_wr) begin
        press_q <= 1'b0;
      end
    end
  end

  // Key data captured after debounce, masked keys left alone
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      avail_q    <= 1'b0;
      o_key_data <= 16'h0000;
    end else if (state_q == KS_SCAN && key_done && !key_wr) begin
      avail_q    <= 1'b1;                                      // see RULE10
      o_key_data <= (o_key_data & key_mask_q) |
                    (key_sync_q & ~key_mask_q);                // see RULE19
    end else if (state_d == KS_SCAN && state_q != KS_SCAN) begin
      avail_q <= 1'b0;                                         // see RULE10
    end
  end

  // Read answer one cycle after the command; unmapped reads zero
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rd_valid <= 1'b0;
      o_rdata    <= 16'h0000;
    end else begin
      o_rd_valid <= rd_en;
      if (rd_en) begin
        case (i_cmd[14:0])
          CMD_ADC_CTRL: o_rdata <= {2'h0, adc_ctrl_q};
          CMD_KEY_CTRL: o_rdata <= {press_q, avail_q, dbn_q, hld_q,
                                    8'h00};                    // see RULE20
          CMD_DAC_CTRL: o_rdata <= {o_dac_power_down, 15'h0000}; // see RULE20
          CMD_KEY_MASK: o_rdata <= key_mask_q;
          default:      o_rdata <= 16'h0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_avg_write;
    wr_en && i_cmd[14:0] == CMD_ADC_CTRL
      |=> o_average_select == $past(i_wdata[7:6]);
  endproperty
  a_avg_write: assert property (p_avg_write) // see RULE1
    else $error("averaging field not taken");
  property p_settle_readback;
    wr_en && i_cmd[14:0] == CMD_ADC_CTRL ##1 !wr_en[*2] ##1
      rd_en && i_cmd[14:0] == CMD_ADC_CTRL
      |=> o_rdata[3:1] == $past(i_wdata[3:1], 4);
  endproperty
  a_settle_readback: assert property (p_settle_readback) // see RULE4
    else $error("settle field readback wrong");
  property p_rfv_write;
    wr_en && i_cmd[14:0] == CMD_ADC_CTRL
      |=> o_ref_voltage_select == $past(i_wdata[0]);
  endproperty
  a_rfv_write: assert property (p_rfv_write) // see RULE5
    else $error("reference select not taken");
  property p_ref_hold;
    wr_en && i_cmd[14:0] == CMD_ADC_CTRL && i_wdata[13:10] != 4'h0
      |=> $stable(o_ref_mode);
  endproperty
  a_ref_hold: assert property (p_ref_hold) // see RULE6
    else $error("reference power moved on measurement write");
  property p_dac_pd;
    wr_en && i_cmd[14:0] == CMD_DAC_CTRL
      |=> o_dac_power_down == $past(i_wdata[15]);
  endproperty
  a_dac_pd: assert property (p_dac_pd) // see RULE8
    else $error("DAC power-down not taken");
  property p_reserved_zero;
    rd_en && (i_cmd[14:0] == CMD_DAC_CTRL || i_cmd[14:0] == CMD_KEY_CTRL)
      |=> o_rd_valid && o_rdata[7:0] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // see RULE20
    else $error("reserved bits not zero");
  property p_off_quiet;
    key_wr && i_wdata[15:14] == 2'b11 ##1 !key_wr
      |-> !o_key_detect_on && !o_key_irq;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // see RULE14
    else $error("press detection active while off");
  property p_host_wait;
    o_key_irq && !auto_q && !key_wr |-> state_q == KS_HOST;
  endproperty
  a_host_wait: assert property (p_host_wait) // see RULE11
    else $error("manual mode did not wait for host");
  property p_direct_start;
    i_pen_detect && !pen_touch |=> o_conv_start;
  endproperty
  a_direct_start: assert property (p_direct_start) // see RULE3
    else $error("non-touch measurement delayed");
  property p_mask_keep;
    $stable(key_mask_q) |-> ((o_key_data ^ $past(o_key_data)) &
                             key_mask_q) == 16'h0000;
  endproperty
  a_mask_keep: assert property (p_mask_keep) // see RULE19
    else $error("masked key data changed");
endmodule // kpc_ctrl_regs

// File: rtl/kpc_pkg.sv
// Constants and types shared by the control register bank
package kpc_pkg;
  localparam logic [14:0] CMD_ADC_CTRL    = 15'h0040;
  localparam logic [14:0] CMD_KEY_CTRL    = 15'h0041;
  localparam logic [14:0] CMD_DAC_CTRL    = 15'h0042;
  localparam logic [14:0] CMD_KEY_MASK    = 15'h0050;
  localparam int          CMD_READ_BIT    = 15;
  localparam int          ADC_SCAN_LSB    = 10;
  localparam int          ADC_RES_LSB     = 8;
  localparam int          ADC_AVG_LSB     = 6;
  localparam int          ADC_SETTLE_LSB  = 1;
  localparam int          ADC_RFV_BIT     = 0;
  localparam int          DAC_PD_BIT      = 15;
  localparam int          KEY_IRQ_BIT     = 15;
  localparam int          KEY_SCAN_BIT    = 14;
  localparam int          KEY_DBN_LSB     = 11;
  localparam int          KEY_HLD_LSB     = 8;
  localparam logic [13:0] ADC_CTRL_RST    = 14'h0000;
  localparam logic        DAC_PD_RST      = 1'h0;
  localparam logic [2:0]  KEY_DBN_RST     = 3'h0;
  localparam logic [2:0]  KEY_HLD_RST     = 3'h0;
  localparam logic [15:0] KEY_MASK_RST    = 16'h0000;
  localparam logic [3:0]  SCAN_REF_ONLY   = 4'h0;
  localparam logic [3:0]  SCAN_TOUCH_LAST = 4'h5;
  localparam int          CLK_MHZ         = 200;
  localparam int          TICK_US         = 1;
  localparam int          US_CYCLES       = TICK_US * CLK_MHZ;
  typedef logic [19:0] us_count_t;
  localparam us_count_t SETTLE_US [8] = '{
    20'd0, 20'd100, 20'd500, 20'd1000,
    20'd5000, 20'd10000, 20'd50000, 20'd100000};
  localparam us_count_t DEBOUNCE_US [8] = '{
    20'd2000, 20'd10000, 20'd20000, 20'd50000,
    20'd60000, 20'd80000, 20'd100000, 20'd120000};
  localparam us_count_t HOLD_SHORT_US = 20'd100;
  typedef enum logic [1:0] {
    REF_AUTO = 2'b00,
    REF_ON   = 2'b01,
    REF_EXT  = 2'b10
  } ref_mode_e;
  typedef enum logic [2:0] {
    KS_OFF  = 3'b000,
    KS_WAIT = 3'b001,
    KS_SCAN = 3'b010,
    KS_HOLD = 3'b011,
    KS_HOST = 3'b100
  } key_state_e;
endpackage

// File: rtl/us_countdown.sv
// Loadable countdown in microsecond ticks, done pulse at zero
module us_countdown (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_tick,
  input  wire logic               i_load,
  input  wire logic               i_abort,
  input  wire kpc_pkg::us_count_t i_count,
  output logic                    o_done
);
  import kpc_pkg::*;

  us_count_t cnt_q;
  logic      busy_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q  <= 20'h0;
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_abort) begin
      busy_q <= 1'b0;
      o_done <= 1'b0;
    end else if (i_load) begin
      cnt_q  <= i_count;
      busy_q <= 1'b1;
      o_done <= 1'b0;
    end else begin
      // Zero count finishes the cycle after load
      o_done <= busy_q && (cnt_q == 20'h0);
      if (busy_q && cnt_q == 20'h0) begin
        busy_q <= 1'b0;
      end else if (busy_q && i_tick) begin
        cnt_q <= cnt_q - 20'h1;
      end
    end
  end
endmodule // us_countdown

// File: rtl/us_tick_gen.sv
// Microsecond enable pulse divided down from the system clock
module us_tick_gen #(
  parameter int DIV = 200
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_tick
);
  logic [31:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q  <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt_q == 32'(DIV - 1)) begin
      cnt_q  <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // us_tick_gen
